// File: rtl/system_watchdog_timer.sv
// System watchdog timer with a classic Wishbone register slave and one interrupt line.
// Assumes one 10 MHz clock, a synchronous active-high reset that is the application reset,
// and that reset_req_o is routed to the system reset controller.
// Limitation: the prewarning time is fixed when the block is built.
// Software can neither lengthen nor shorten it.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module system_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned DIV_L = DIV_LONG,
  parameter int unsigned DIV_S = DIV_SHORT
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic prewarn_o,
  output logic reset_req_o
);

  localparam int unsigned PRE_W = $clog2(DIV_L);
  localparam int unsigned DLY_W = $clog2(PREWARN_CYCLES + 1);

  // The prescaler compare assumes both ratios are powers of two that fit its width.
  if (CNT_W != 16 || DIV_L <= DIV_S || DIV_S < 2 ||
      (DIV_L & (DIV_L - 1)) != 0 || (DIV_S & (DIV_S - 1)) != 0) begin : bad_params
    $error("system_watchdog_timer: unsupported counter width or prescaler ratios");
  end

  // The register images are 32 bits wide, so every field must end inside a word.
  // The delay counter must also hold the last prewarning cycle.
  if (CFG_RELOAD_LSB + CNT_W > 32 || ST_COUNT_LSB + CNT_W > 32 || EV_W != 2 ||
      PREWARN_CYCLES < 1 || PREWARN_CYCLES >= (1 << DLY_W)) begin : bad_layout
    $error("system_watchdog_timer: register layout or prewarning time does not fit");
  end

  // Returns the last prescaler value before a counter step for the selected ratio.
  function automatic logic [PRE_W-1:0] div_last(input logic sel);
    div_last = sel ? PRE_W'(DIV_S - 1) : PRE_W'(DIV_L - 1);
  endfunction

  // A command bit acts only when its byte lane is written.
  // A write with that lane off leaves the watchdog untouched.
  function automatic logic cmd_set(input logic [31:0] wr, input logic [3:0] sel,
                                   input int unsigned pos);
    cmd_set = sel[pos / 8] && wr[pos];
  endfunction

  // Byte-lane merge of a write into a 32-bit register image.
  // Lanes that are not selected keep their old contents.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wr,
                                             input logic [3:0] sel);
    lane_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        lane_merge[8*i +: 8] = wr[8*i +: 8];
      end
    end
  endfunction

  // Registers of the block.
  logic div_sel;
  logic [CNT_W-1:0] reload;
  logic enabled;
  logic [PRE_W-1:0] prescale;
  logic [CNT_W-1:0] count;
  phase_t phase;
  logic [DLY_W-1:0] delay;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] mask;

  // Decode and strobes, all combinational.
  logic bus_req;
  logic wr_stb;
  logic rd_stb;
  logic do_service;
  logic do_enable;
  logic do_disable;
  logic step;
  logic overflow;
  logic fire_reset;
  logic [EV_W-1:0] ev_set;
  logic [31:0] cfg_image;
  logic [31:0] cfg_new;
  logic [31:0] next_rdata;
  logic [EV_W-1:0] next_events;
  // Address decode, read image and next phase.
  logic hit_config;
  logic hit_command;
  logic hit_events;
  logic hit_mask;
  logic [31:0] st_image;
  phase_t next_phase;
  logic [DLY_W-1:0] next_delay;

  // A request is taken on the edge where ack rises; ack then drops for one cycle.
  // Every offset, mapped or not, is answered one cycle after it is taken, so a
  // master never waits longer than that.
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = bus_req && wb_we_i;
  assign rd_stb = bus_req && !wb_we_i;

  // Unmapped offsets hit nothing: they are answered, read as zero and ignore writes.
  assign hit_config = wb_adr_i == ADDR_CONFIG;
  assign hit_command = wb_adr_i == ADDR_COMMAND;
  assign hit_events = wb_adr_i == ADDR_EVENTS;
  assign hit_mask = wb_adr_i == ADDR_MASK;

  // Commands are one-shot: nothing of a command write is kept for a later strobe.
  assign do_service = wr_stb && hit_command &&
                      cmd_set(wb_dat_i, wb_sel_i, CMD_SERVICE_BIT);
  assign do_enable = wr_stb && hit_command &&
                     cmd_set(wb_dat_i, wb_sel_i, CMD_ENABLE_BIT);
  assign do_disable = wr_stb && hit_command &&
                      cmd_set(wb_dat_i, wb_sel_i, CMD_DISABLE_BIT);

  // A counter step happens when the prescaler completes one full ratio.
  // With the short ratio and an all-ones reload the interval is a single
  // prescaler period; the long ratio and a zero reload give the longest one.
  assign step = enabled && prescale == div_last(div_sel);
  assign overflow = step && count == '1;
  // The delay stands at PREWARN_CYCLES - 1 in the last prewarning cycle, so the
  // request rises PREWARN_CYCLES cycles after the phase is entered.
  assign fire_reset = phase == PHASE_PREWARN && delay == DLY_W'(PREWARN_CYCLES - 1);

  // Only the first overflow is an event; later ones fall in the prewarning or reset phase.
  assign ev_set[EV_PREWARN_BIT] = overflow && phase == PHASE_WATCH;
  assign ev_set[EV_RESET_BIT] = fire_reset;

  // The reload field may be written one byte lane at a time.
  always_comb begin
    cfg_image = '0;
    cfg_image[CFG_SEL_BIT] = div_sel;
    cfg_image[CFG_RELOAD_LSB +: CNT_W] = reload;
  end

  assign cfg_new = lane_merge(cfg_image, wb_dat_i, wb_sel_i);

  always_comb begin
    st_image = '0;
    st_image[ST_ENABLED_BIT] = enabled;
    st_image[ST_PREWARN_BIT] = phase == PHASE_PREWARN;
    st_image[ST_RESET_BIT] = phase == PHASE_RESET;
    st_image[ST_COUNT_LSB +: CNT_W] = count;
  end

  // Read data follows the address alone; only a read strobe loads it.
  // The command offset reads as zero because commands are never stored.
  always_comb begin
    next_rdata = '0;
    unique case (wb_adr_i)
      ADDR_CONFIG: next_rdata = cfg_image;
      ADDR_STATE: next_rdata = st_image;
      ADDR_EVENTS: next_rdata[EV_W-1:0] = events;
      ADDR_MASK: next_rdata[EV_W-1:0] = mask;
      default: next_rdata = '0;
    endcase
  end

  // A read of the event register clears it, but an event in the same cycle survives.
  // Losing that event would hide an overflow from the interrupt handler.
  always_comb begin
    next_events = events;
    if (rd_stb && hit_events) begin
      next_events = '0;
    end
    next_events = next_events | ev_set;
  end

  // Ack rises one cycle after the request is taken and falls in the next, so a
  // master that holds its strobe through the ack is never answered twice.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data is registered with the ack and then held until the next read.
  // Holding it costs a register but lets a slow master sample it late.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wb_dat_o <= '0;
    end else if (rd_stb) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Configuration: prescaler select and reload value; defaults give about 6.55 ms at 10 MHz.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div_sel <= SEL_RESET;
      reload <= RELOAD_RESET;
    end else if (wr_stb && hit_config) begin
      div_sel <= cfg_new[CFG_SEL_BIT];
      reload <= cfg_new[CFG_RELOAD_LSB +: CNT_W];
    end
  end

  // Run state; disable wins if both commands are written at once.
  // Disabling freezes prescaler and counter where they stand; enabling resumes there.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      enabled <= 1'b1;
    end else if (do_disable) begin
      enabled <= 1'b0;
    end else if (do_enable) begin
      enabled <= 1'b1;
    end
  end

  // Prescaler: cleared by a service and after each completed ratio.
  // Clearing it on a service makes the first interval after a service a full one.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prescale <= '0;
    end else if (do_service || step) begin
      prescale <= '0;
    end else if (enabled) begin
      prescale <= prescale + PRE_W'(1);
    end
  end

  // Counter: reloaded by a service and after an overflow, otherwise counts up.
  // A service in the overflow cycle loads the same value, so neither path must win.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      count <= RELOAD_RESET;
    end else if (do_service || overflow) begin
      count <= reload;
    end else if (step) begin
      count <= count + CNT_W'(1);
    end
  end

  // Once overflow is seen the reset request follows after a fixed prewarning time.
  // A service or disable cannot call it back; only the application reset ends it.
  // Later overflows in the prewarning phase are ignored on purpose: the delay is
  // already running and a second prewarning would only hide the first.
  always_comb begin
    next_phase = phase;
    next_delay = '0;
    unique case (phase)
      PHASE_WATCH: begin
        if (overflow) begin
          next_phase = PHASE_PREWARN;
        end
      end
      PHASE_PREWARN: begin
        next_delay = delay + DLY_W'(1);
        if (fire_reset) begin
          next_phase = PHASE_RESET;
        end
      end
      PHASE_RESET: next_delay = '0;
    endcase
  end

  // The phase and its delay are registered together so they never disagree.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      phase <= PHASE_WATCH;
      delay <= '0;
    end else begin
      phase <= next_phase;
      delay <= next_delay;
    end
  end

  // Prewarning is raised from the overflow cycle itself so that the pin and the
  // event bit move together.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prewarn_o <= 1'b0;
    end else begin
      prewarn_o <= phase == PHASE_PREWARN || ev_set[EV_PREWARN_BIT];
    end
  end

  // The request is sticky: once given, only the application reset clears it.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reset_req_o <= 1'b0;
    end else begin
      reset_req_o <= reset_req_o || fire_reset;
    end
  end

  // Sticky events and mask; the interrupt follows one cycle after the status.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      events <= '0;
    end else begin
      events <= next_events;
    end
  end

  // Only lane 0 carries mask bits; the other lanes are ignored rather than stored.
  // A cleared mask bit keeps the event readable but silent.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mask <= '0;
    end else if (wr_stb && hit_mask && wb_sel_i[0]) begin
      mask <= wb_dat_i[EV_W-1:0];
    end
  end

  // The interrupt is registered so the pin comes straight from a flip-flop; it
  // therefore trails the event bit by one cycle.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(events & mask);
    end
  end

endmodule // system_watchdog_timer

`default_nettype wire

// File: rtl/wdt_pkg.sv
// Constants shared by the watchdog timer: register map, field layout, reset values, timing.
// Assumes a 32-bit classic Wishbone slave port and a 10 MHz system clock.
package wdt_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;

  // Word-aligned byte offsets of the registers.
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_COMMAND = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_EVENTS = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;

  // Config register fields.
  localparam int unsigned CFG_SEL_BIT = 0;
  localparam int unsigned CFG_RELOAD_LSB = 16;

  // Command register bits; each is a one-shot action.
  localparam int unsigned CMD_SERVICE_BIT = 0;
  localparam int unsigned CMD_ENABLE_BIT = 1;
  localparam int unsigned CMD_DISABLE_BIT = 2;

  // State register fields.
  localparam int unsigned ST_ENABLED_BIT = 0;
  localparam int unsigned ST_PREWARN_BIT = 1;
  localparam int unsigned ST_RESET_BIT = 2;
  localparam int unsigned ST_COUNT_LSB = 16;

  // Event and mask bits.
  localparam int unsigned EV_PREWARN_BIT = 0;
  localparam int unsigned EV_RESET_BIT = 1;
  localparam int unsigned EV_W = 2;

  // Prescaler select: 0 divides by the long ratio, 1 by the short ratio.
  localparam int unsigned DIV_LONG = 16384;
  localparam int unsigned DIV_SHORT = 256;
  localparam logic SEL_RESET = 1'b1;
  localparam logic [15:0] RELOAD_RESET = 16'hFF00;

  // Time from prewarning to the reset request, and its cycle count (least time, rounded up).
  localparam int unsigned PREWARN_NS = 12800;
  localparam int unsigned PREWARN_CYC_RAW =
    (PREWARN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PREWARN_CYCLES = (PREWARN_CYC_RAW < 1) ? 1 : PREWARN_CYC_RAW;

  typedef enum logic [1:0] {
    PHASE_WATCH,
    PHASE_PREWARN,
    PHASE_RESET
  } phase_t;

endpackage

// File: tb/system_watchdog_timer_props.sv
// Port checker for the watchdog timer.
// Assumes the master keeps the classic single-cycle Wishbone handshake.
`timescale 1ns/1ns
`default_nettype none
module system_watchdog_timer_props import wdt_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic prewarn_o,
  input wire logic reset_req_o
);
  logic take;
  logic [1:0] mask_sh;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // A shadow of the mask lets the interrupt be judged without seeing inside.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mask_sh <= 2'h0;
    end else if (take && wb_we_i && wb_adr_i == ADDR_MASK && wb_sel_i[0]) begin
      mask_sh <= wb_dat_i[1:0];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_reset_quiet: assert property (disable iff (1'b0) reset_i |=>
    !wb_ack_o && !irq_o && !prewarn_o && !reset_req_o) else $error("outputs after reset");
  a_request_sticky: assert property (reset_req_o |=> reset_req_o)
    else $error("reset request dropped");
  a_prewarn_first: assert property ($rose(reset_req_o) |-> $past(prewarn_o))
    else $error("reset request without prewarning");
  a_prewarn_delay: assert property ($rose(prewarn_o) |-> ##[126:130] $rose(reset_req_o))
    else $error("prewarning delay wrong");
  a_irq_masked: assert property (irq_o |-> $past(mask_sh) != 2'h0)
    else $error("interrupt while masked");
  a_prewarn_irq: assert property ($rose(prewarn_o) && mask_sh[0] |-> ##[0:2] irq_o)
    else $error("prewarning interrupt missing");
  c_write: cover property (take && wb_we_i);
  c_irq: cover property ($rose(irq_o));
  c_request: cover property ($rose(reset_req_o));
endmodule // system_watchdog_timer_props

bind system_watchdog_timer system_watchdog_timer_props system_watchdog_timer_props_i (
  .ref_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .irq_o, .prewarn_o, .reset_req_o);
`default_nettype wire

// File: tb/system_watchdog_timer_tb.sv
// Self-checking bench: register access, service, disable, overflow and reset request.
// Assumes one 10 MHz clock and a block that answers every Wishbone request.
`timescale 1ns/1ns
`default_nettype none
module system_watchdog_timer_tb import wdt_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic [31:0] rd;
  logic ack, irq, prewarn, rst_req;
  int failures = 0;
  int comparisons = 0;
  int n;
  always #50 ref_clk_i = ~ref_clk_i;
  system_watchdog_timer system_watchdog_timer_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq),
    .prewarn_o(prewarn), .reset_req_o(rst_req));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered right after a rising edge; the request holds until ack is sampled.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) failures++;
    rd = dat_r;
    req <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wait_hi(input logic which, output int c);
    c = 0;
    while ((which ? rst_req : prewarn) !== 1'b1 && c < 20000) begin
      @(posedge ref_clk_i);
      c++;
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    bus(0, ADDR_CONFIG, 0);
    check(rd, 32'hFF000001);
    bus(0, ADDR_STATE, 0);
    check(rd, 32'hFF000001);
    bus(0, 8'h40, 0);
    check(rd, 32'h0);
    bus(1, ADDR_COMMAND, 32'h4);
    bus(1, ADDR_COMMAND, 32'h1);
    repeat (600) @(posedge ref_clk_i);
    bus(0, ADDR_STATE, 0);
    check(rd, 32'hFF000000);
    bus(1, ADDR_COMMAND, 32'h2);
    repeat (700) @(posedge ref_clk_i);
    bus(0, ADDR_STATE, 0);
    check(rd, 32'hFF020001);
    // Mid-prescale service: an uncleared prescaler would step within the wait.
    repeat (150) @(posedge ref_clk_i);
    bus(1, ADDR_COMMAND, 32'h1);
    repeat (200) @(posedge ref_clk_i);
    bus(0, ADDR_STATE, 0);
    check(rd, 32'hFF000001);
    bus(1, ADDR_MASK, 32'h3);
    bus(1, ADDR_CONFIG, 32'hFFFE0001);
    bus(1, ADDR_COMMAND, 32'h1);
    wait_hi(1'b0, n);
    check(32'(n > 505 && n < 515), 32'h1);
    @(posedge ref_clk_i);
    check({29'h0, irq, prewarn, rst_req}, 32'h6);
    bus(0, ADDR_EVENTS, 0);
    check(rd, 32'h1);
    bus(0, ADDR_STATE, 0);
    check(rd, 32'hFFFE0003);
    wait_hi(1'b1, n);
    check(32'(n > 110 && n < 130), 32'h1);
    bus(0, ADDR_EVENTS, 0);
    check(rd, 32'h2);
    bus(1, ADDR_COMMAND, 32'h5);
    bus(0, ADDR_EVENTS, 0);
    check(rd, 32'h0);
    check({29'h0, irq, prewarn, rst_req}, 32'h1);
    reset_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    check({29'h0, irq, prewarn, rst_req}, 32'h0);
    bus(1, ADDR_CONFIG, 32'hFFFF0000);
    bus(1, ADDR_COMMAND, 32'h1);
    wait_hi(1'b0, n);
    check(32'(n > 16375 && n < 16390), 32'h1);
    @(posedge ref_clk_i);
    check({31'h0, irq}, 32'h0);
    tally_and_finish();
  end
endmodule // system_watchdog_timer_tb
`default_nettype wire
